/* File: hdl/timer_8bit_pwm_mode.sv */
// Eight-bit PWM mode of one timer channel with register port
`timescale 1ns/1ns
`default_nettype none
module timer_8bit_pwm_mode #(
  parameter int unsigned ADDR_W = pwm_timer_pkg::ADDR_W,
  parameter int unsigned DATA_W = pwm_timer_pkg::DATA_W
) (
  input  wire logic              clock_i,
  input  wire logic              resetn_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DATA_W-1:0] rdata_o,
  input  wire logic              low_freq_clock_i,
  input  wire logic              low_power_sleep_mode_i,
  output logic                   pwm_output_pin_o,
  output logic                   pwm_output_oe_o,
  output logic                   channel0_irq_o
);

  typedef enum logic [1:0] {
    ST_STOPPED = 2'b00,
    ST_COUNT   = 2'b01,
    ST_EXTEND  = 2'b10
  } run_state_t;

  run_state_t  state_r;
  run_state_t  state_nxt;
  logic [7:0]  ctl_r;
  logic [7:0]  mod_r;
  logic [6:0]  duty_act_r;
  logic        extra_act_r;
  logic [6:0]  duty_buf_r;
  logic        extra_buf_r;
  logic [6:0]  count_r;
  logic [6:0]  count_nxt;
  logic        level_r;
  logic        level_nxt;
  logic        phase_r;
  logic        phase_nxt;
  logic        matched_r;
  logic        matched_nxt;
  logic        irq_nxt;
  logic [7:0]  rdata_nxt;
  logic        source_tick;

  // Decoded control fields
  logic        channel0_run;
  logic        pin_function;
  logic        initial_level_select;
  logic        double_buffer_enable;
  logic        slow_divider_select;
  logic [2:0]  source_clock_select;
  logic        running;

  // Bus decode
  logic        wr_ctl;
  logic        wr_mod;
  logic        wr_duty;
  logic [6:0]  wr_duty_val;
  logic        wr_extra_val;
  logic        take_buffered;

  // Period events
  logic        duty_hit;
  logic        want_extend;
  logic        overflow;
  logic        even_overflow;
  logic        ext_done;
  logic [6:0]  duty_eff;

  assign channel0_run         = ctl_r[pwm_timer_pkg::CTL_RUN_BIT];
  assign pin_function         = ctl_r[pwm_timer_pkg::CTL_PIN_FUN_BIT];
  assign initial_level_select = mod_r[pwm_timer_pkg::MOD_INIT_LEVEL_BIT];
  assign double_buffer_enable = mod_r[pwm_timer_pkg::MOD_DBE_BIT];
  assign slow_divider_select  = mod_r[pwm_timer_pkg::MOD_SLOW_DIV_BIT];
  assign source_clock_select  = mod_r[pwm_timer_pkg::MOD_CLK_SEL_LSB +: pwm_timer_pkg::CLK_SEL_W];
  assign running              = (state_r != ST_STOPPED);

  assign wr_ctl       = wr_i & (addr_i == pwm_timer_pkg::OFF_TIMER_PAIR_CONTROL);
  // Mode settings are frozen while the timer runs
  assign wr_mod       = wr_i & (addr_i == pwm_timer_pkg::OFF_CHANNEL0_MODE) & ~running;
  assign wr_duty      = wr_i & (addr_i == pwm_timer_pkg::OFF_DUTY_REGISTER);
  assign wr_duty_val  = wdata_i[pwm_timer_pkg::DUTY_W-1:0];
  assign wr_extra_val = wdata_i[pwm_timer_pkg::DUTY_EXTRA_BIT];
  assign take_buffered = wr_duty & running & double_buffer_enable;

  // Prescaler runs only while counting
  source_clock_prescaler u_prescaler (
    .clock_i                (clock_i),
    .resetn_i               (resetn_i),
    .enable_i               (running),
    .source_clock_select_i  (source_clock_select),
    .slow_divider_select_i  (slow_divider_select),
    .low_power_sleep_mode_i (low_power_sleep_mode_i),
    .low_freq_clock_i       (low_freq_clock_i),
    .tick_o                 (source_tick)
  );

  // Unbuffered running write is seen by the comparator at once
  assign duty_eff      = (wr_duty & running & ~double_buffer_enable) ? wr_duty_val : duty_act_r;
  // Equality on the live count so a write equal to the count hits now
  assign duty_hit      = (state_r == ST_COUNT) & ~matched_r & (count_r == duty_eff);
  assign want_extend   = extra_act_r & phase_r;
  assign ext_done      = (state_r == ST_EXTEND) & source_tick;
  assign overflow      = running & source_tick & (count_r == pwm_timer_pkg::CNT_LAST) & ~ext_done;
  assign even_overflow = overflow & phase_r;
  assign irq_nxt       = even_overflow;

  // Counter, output level, phase and state
  always_comb begin
    state_nxt   = state_r;
    count_nxt   = count_r;
    level_nxt   = level_r;
    phase_nxt   = phase_r;
    matched_nxt = matched_r;
    case (state_r)
      ST_STOPPED: begin
        count_nxt   = pwm_timer_pkg::CNT_CLEAR;
        level_nxt   = initial_level_select;
        phase_nxt   = 1'b0;
        matched_nxt = 1'b0;
        if (channel0_run) begin
          state_nxt = ST_COUNT;
        end
      end
      ST_COUNT: begin
        if (duty_hit) begin
          matched_nxt = 1'b1;
          if (want_extend) begin
            state_nxt = ST_EXTEND;
          end else begin
            level_nxt = ~initial_level_select;
          end
        end
        if (overflow) begin
          count_nxt   = pwm_timer_pkg::CNT_CLEAR;
          level_nxt   = initial_level_select;
          phase_nxt   = ~phase_r;
          matched_nxt = 1'b0;
        end else if (source_tick) begin
          count_nxt = count_r + 7'h01;
        end
      end
      ST_EXTEND: begin
        if (source_tick) begin
          level_nxt = ~initial_level_select;
          state_nxt = ST_COUNT;
          if (count_r == pwm_timer_pkg::CNT_LAST) begin
            count_nxt   = pwm_timer_pkg::CNT_CLEAR;
            phase_nxt   = ~phase_r;
            matched_nxt = 1'b0;
          end else begin
            count_nxt = count_r + 7'h01;
          end
        end
      end
      default: begin
        state_nxt = ST_STOPPED;
      end
    endcase
    if (!channel0_run) begin
      state_nxt = ST_STOPPED;
      count_nxt = pwm_timer_pkg::CNT_CLEAR;
      level_nxt = initial_level_select;
    end
  end

  // Read data multiplexer
  always_comb begin
    rdata_nxt = 8'h00;
    if (rd_i) begin
      case (addr_i)
        pwm_timer_pkg::OFF_TIMER_PAIR_CONTROL: rdata_nxt = ctl_r;
        pwm_timer_pkg::OFF_CHANNEL0_MODE:      rdata_nxt = mod_r;
        pwm_timer_pkg::OFF_DUTY_REGISTER: begin
          if (double_buffer_enable) begin
            rdata_nxt = {extra_buf_r, duty_buf_r};
          end else begin
            rdata_nxt = {extra_act_r, duty_act_r};
          end
        end
        pwm_timer_pkg::OFF_STATUS: begin
          rdata_nxt[pwm_timer_pkg::STS_RUN_BIT]   = running;
          rdata_nxt[pwm_timer_pkg::STS_LEVEL_BIT] = level_r;
          rdata_nxt[pwm_timer_pkg::STS_PHASE_BIT] = phase_r;
          rdata_nxt[pwm_timer_pkg::STS_EXT_BIT]   = (state_r == ST_EXTEND);
        end
        pwm_timer_pkg::OFF_COUNT: rdata_nxt = {1'b0, count_r};
        default:                  rdata_nxt = 8'h00;
      endcase
    end
  end

  // Control and mode registers
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctl_r <= pwm_timer_pkg::CTL_RESET;
      mod_r <= pwm_timer_pkg::MOD_RESET;
    end else begin
      if (wr_ctl) begin
        ctl_r <= wdata_i;
      end
      if (wr_mod) begin
        mod_r <= wdata_i;
      end
    end
  end

  // Duty registers: active compare value and buffer
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      duty_act_r  <= pwm_timer_pkg::DUTY_RESET[6:0];
      extra_act_r <= pwm_timer_pkg::DUTY_RESET[7];
      duty_buf_r  <= pwm_timer_pkg::DUTY_RESET[6:0];
      extra_buf_r <= pwm_timer_pkg::DUTY_RESET[7];
    end else begin
      if (wr_duty) begin
        duty_buf_r  <= wr_duty_val;
        extra_buf_r <= wr_extra_val;
      end
      if (wr_duty & ~take_buffered) begin
        duty_act_r  <= wr_duty_val;
        extra_act_r <= wr_extra_val;
      end else if (even_overflow & double_buffer_enable) begin
        duty_act_r  <= duty_buf_r;
        extra_act_r <= extra_buf_r;
      end
    end
  end

  // Timer state
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r   <= ST_STOPPED;
      count_r   <= pwm_timer_pkg::CNT_CLEAR;
      level_r   <= 1'b0;
      phase_r   <= 1'b0;
      matched_r <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      count_r   <= count_nxt;
      level_r   <= level_nxt;
      phase_r   <= phase_nxt;
      matched_r <= matched_nxt;
    end
  end

  // Registered outputs
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o          <= 8'h00;
      pwm_output_pin_o <= 1'b0;
      pwm_output_oe_o  <= 1'b0;
      channel0_irq_o   <= 1'b0;
    end else begin
      rdata_o          <= rdata_nxt;
      pwm_output_pin_o <= level_nxt;
      pwm_output_oe_o  <= pin_function;
      channel0_irq_o   <= irq_nxt;
    end
  end

endmodule // timer_8bit_pwm_mode
`default_nettype wire

/* File: common/pwm_timer_pkg.sv */
// Constants shared by the eight-bit PWM timer channel
package pwm_timer_pkg;

  // Register bus geometry
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;

  // Register offsets
  localparam logic [3:0] OFF_TIMER_PAIR_CONTROL = 4'h0;
  localparam logic [3:0] OFF_CHANNEL0_MODE      = 4'h1;
  localparam logic [3:0] OFF_DUTY_REGISTER      = 4'h2;
  localparam logic [3:0] OFF_STATUS             = 4'h3;
  localparam logic [3:0] OFF_COUNT              = 4'h4;

  // timer_pair_control fields
  localparam int unsigned CTL_RUN_BIT     = 0;
  localparam int unsigned CTL_PIN_FUN_BIT = 1;

  // channel0_mode_register fields
  localparam int unsigned MOD_INIT_LEVEL_BIT = 0;
  localparam int unsigned MOD_DBE_BIT        = 1;
  localparam int unsigned MOD_SLOW_DIV_BIT   = 2;
  localparam int unsigned MOD_CLK_SEL_LSB    = 4;
  localparam int unsigned CLK_SEL_W          = 3;

  // duty_register fields
  localparam int unsigned DUTY_W         = 7;
  localparam int unsigned DUTY_EXTRA_BIT = 7;

  // status fields
  localparam int unsigned STS_RUN_BIT   = 0;
  localparam int unsigned STS_LEVEL_BIT = 1;
  localparam int unsigned STS_PHASE_BIT = 2;
  localparam int unsigned STS_EXT_BIT   = 3;

  // Reset values
  localparam logic [7:0] CTL_RESET  = 8'h00;
  localparam logic [7:0] MOD_RESET  = 8'h00;
  localparam logic [7:0] DUTY_RESET = 8'h00;

  // Counter geometry: period is 128 source counts
  localparam int unsigned CNT_W       = 7;
  localparam logic [6:0]  CNT_LAST    = 7'h7f;
  localparam logic [6:0]  CNT_CLEAR   = 7'h00;

  // Prescaler geometry
  localparam int unsigned GEAR_DIV_W  = 11;
  localparam int unsigned LF_DIV_W    = 4;

  // Clock select codes
  localparam logic [2:0] CKS_DIV2048 = 3'h0;
  localparam logic [2:0] CKS_DIV1024 = 3'h1;
  localparam logic [2:0] CKS_DIV256  = 3'h2;
  localparam logic [2:0] CKS_DIV64   = 3'h3;
  localparam logic [2:0] CKS_DIV16   = 3'h4;
  localparam logic [2:0] CKS_DIV4    = 3'h5;
  localparam logic [2:0] CKS_DIV2    = 3'h6;
  localparam logic [2:0] CKS_DIV1    = 3'h7;

  // Low-frequency clock divider masks
  localparam logic [3:0] LF_MASK_DIV16 = 4'hf;
  localparam logic [3:0] LF_MASK_DIV8  = 4'h7;
  localparam logic [3:0] LF_MASK_DIV4  = 4'h3;

endpackage

/* File: hdl/source_clock_prescaler.sv */
// Source clock prescaler giving one count pulse per selected source period
`timescale 1ns/1ns
`default_nettype none
module source_clock_prescaler (
  input  wire logic       clock_i,
  input  wire logic       resetn_i,
  input  wire logic       enable_i,
  input  wire logic [2:0] source_clock_select_i,
  input  wire logic       slow_divider_select_i,
  input  wire logic       low_power_sleep_mode_i,
  input  wire logic       low_freq_clock_i,
  output logic            tick_o
);

  logic [10:0] gear_div_r;
  logic [10:0] gear_div_nxt;
  logic [3:0]  lf_div_r;
  logic [3:0]  lf_div_nxt;
  logic        lf_prev_r;
  logic        lf_rise;
  logic [10:0] gear_mask;
  logic [3:0]  lf_mask;
  logic        use_lf;
  logic        lf_valid;
  logic        gear_tick;
  logic        lf_tick;
  logic        tick_nxt;

  // Gear divider mask per select code
  function automatic logic [10:0] gear_mask_of(input logic [2:0] code);
    case (code)
      pwm_timer_pkg::CKS_DIV2048: gear_mask_of = 11'h7ff;
      pwm_timer_pkg::CKS_DIV1024: gear_mask_of = 11'h3ff;
      pwm_timer_pkg::CKS_DIV256:  gear_mask_of = 11'h0ff;
      pwm_timer_pkg::CKS_DIV64:   gear_mask_of = 11'h03f;
      pwm_timer_pkg::CKS_DIV16:   gear_mask_of = 11'h00f;
      pwm_timer_pkg::CKS_DIV4:    gear_mask_of = 11'h003;
      pwm_timer_pkg::CKS_DIV2:    gear_mask_of = 11'h001;
      default:                    gear_mask_of = 11'h000;
    endcase
  endfunction

  assign gear_mask    = gear_mask_of(source_clock_select_i);
  assign lf_rise      = low_freq_clock_i & ~lf_prev_r;
  // Low-frequency source: slow select on codes 000/001, sleep on 000/001/111
  assign use_lf       = low_power_sleep_mode_i |
                        (slow_divider_select_i & (source_clock_select_i[2:1] == 2'b00));
  assign lf_valid     = ~low_power_sleep_mode_i | (source_clock_select_i[2:1] == 2'b00) |
                        (source_clock_select_i == pwm_timer_pkg::CKS_DIV1);
  assign lf_mask      = (source_clock_select_i == pwm_timer_pkg::CKS_DIV2048) ? pwm_timer_pkg::LF_MASK_DIV16 :
                        (source_clock_select_i == pwm_timer_pkg::CKS_DIV1024) ? pwm_timer_pkg::LF_MASK_DIV8 :
                                                                              pwm_timer_pkg::LF_MASK_DIV4;
  assign gear_tick    = ((gear_div_r & gear_mask) == gear_mask);
  assign lf_tick      = lf_rise & ((lf_div_r & lf_mask) == lf_mask) & lf_valid;
  assign tick_nxt     = enable_i & (use_lf ? lf_tick : gear_tick);
  assign gear_div_nxt = enable_i ? gear_div_r + 11'h001 : 11'h000;
  assign lf_div_nxt   = ~enable_i ? 4'h0 : (lf_rise ? lf_div_r + 4'h1 : lf_div_r);

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gear_div_r <= 11'h000;
      lf_div_r   <= 4'h0;
      lf_prev_r  <= 1'b0;
      tick_o     <= 1'b0;
    end else begin
      gear_div_r <= gear_div_nxt;
      lf_div_r   <= lf_div_nxt;
      lf_prev_r  <= low_freq_clock_i;
      tick_o     <= tick_nxt;
    end
  end

endmodule // source_clock_prescaler
`default_nettype wire

/* File: verification/pwm_timer_checker.sv */
// Port checker for the PWM timer channel
`timescale 1ns/1ns
`default_nettype none
module pwm_timer_checker #(
  parameter int unsigned ADDR_W = 4,
  parameter int unsigned DATA_W = 8
) (
  input  wire logic              clock_i,
  input  wire logic              resetn_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  input  wire logic [DATA_W-1:0] rdata_o,
  input  wire logic              pwm_output_pin_o,
  input  wire logic              pwm_output_oe_o,
  input  wire logic              channel0_irq_o
);
  logic              run_r;
  logic              init_r;
  logic [DATA_W-1:0] duty_r;
  logic [8:0]        gap_r;
  logic [2:0]        idle_r;
  wire               ctl_wr = wr_i && (addr_i == 4'h0);
  wire               mod_wr = wr_i && (addr_i == 4'h1) && !run_r;
  wire               dty_wr = wr_i && (addr_i == 4'h2);

  // Shadow of software state and event spacing
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      run_r  <= 1'b0;
      init_r <= 1'b0;
      duty_r <= '0;
      gap_r  <= 9'h1ff;
      idle_r <= 3'h0;
    end else begin
      if (ctl_wr) run_r <= wdata_i[0];
      if (mod_wr) init_r <= wdata_i[0];
      if (dty_wr) duty_r <= wdata_i;
      gap_r  <= channel0_irq_o ? 9'h000 : ((gap_r == 9'h1ff) ? gap_r : gap_r + 9'h001);
      idle_r <= (run_r || wr_i) ? 3'h0 : ((idle_r == 3'h7) ? idle_r : idle_r + 3'h1);
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  a_irq_pulse: assert property (channel0_irq_o |=> !channel0_irq_o)
    else $error("irq longer than one cycle");
  a_irq_spacing: assert property (channel0_irq_o |-> gap_r >= 9'h0ff)
    else $error("irq closer than two periods");
  a_irq_run: assert property (channel0_irq_o |-> $past(run_r))
    else $error("irq while stopped");
  a_wrap_level: assert property (channel0_irq_o |-> pwm_output_pin_o == init_r)
    else $error("pin not at initial level at overflow");
  a_stop_level: assert property (idle_r == 3'h7 |-> pwm_output_pin_o == init_r)
    else $error("stopped pin not at initial level");
  a_oe_lag: assert property (ctl_wr |-> ##2 pwm_output_oe_o == $past(wdata_i[1], 2))
    else $error("pin enable does not follow control");
  a_duty_read: assert property (rd_i && addr_i == 4'h2 |=> rdata_o == duty_r)
    else $error("duty read not last written value");
  a_rdata_idle: assert property (!rd_i |=> rdata_o == '0)
    else $error("read data outside read slot");

  c_irq: cover property (channel0_irq_o);
  c_duty_rd: cover property (rd_i && addr_i == 4'h2);
  c_stopped: cover property (idle_r == 3'h7 && pwm_output_oe_o);
endmodule // pwm_timer_checker
`default_nettype wire

/* File: verification/pwm_pin_monitor.sv */
// Model of the circuit on the PWM pin: measures each level run
`timescale 1ns/1ns
`default_nettype none
module pwm_pin_monitor (
  input  wire logic        clock_i,
  input  wire logic        resetn_i,
  input  wire logic        pin_i,
  input  wire logic        oe_i,
  output logic             done_o,
  output logic             lvl_o,
  output logic [15:0]      len_o
);
  logic        prev_r;
  logic [15:0] cnt_r;
  wire         edge_w = pin_i != prev_r;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prev_r <= 1'b0;
      cnt_r  <= 16'h0000;
      done_o <= 1'b0;
      lvl_o  <= 1'b0;
      len_o  <= 16'h0000;
    end else begin
      prev_r <= pin_i;
      done_o <= edge_w && oe_i;
      cnt_r  <= edge_w ? 16'h0000 : cnt_r + 16'h0001;
      if (edge_w) begin
        lvl_o <= prev_r;
        len_o <= cnt_r + 16'h0001;
      end
    end
  end
endmodule // pwm_pin_monitor
`default_nettype wire

/* File: verification/tb_top.sv */
// Testbench for the PWM timer channel
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic        clock_i, resetn_i, wr_i, rd_i, lf_i = 1'b0, sleep_i;
  logic        pin_o, oe_o, irq_o, done_w, lvl_w;
  logic [3:0]  addr_i;
  logic [7:0]  wdata_i, rdata_o, d;
  logic [15:0] len_w, w1, w2;
  logic [7:0]  mtab [6] = '{8'h70, 8'h60, 8'h50, 8'h40, 8'h14, 8'h70};
  logic [15:0] stab [6] = '{16'h0100, 16'h0200, 16'h0400, 16'h1000, 16'h2000, 16'h1000};
  int          n_fail = 0, checks_done = 0, cyc = 0, t0, t1, i;

  timer_8bit_pwm_mode dut (.clock_i(clock_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .low_freq_clock_i(lf_i), .low_power_sleep_mode_i(sleep_i),
    .pwm_output_pin_o(pin_o), .pwm_output_oe_o(oe_o), .channel0_irq_o(irq_o));
  pwm_pin_monitor mon (.clock_i(clock_i), .resetn_i(resetn_i), .pin_i(pin_o), .oe_i(oe_o),
    .done_o(done_w), .lvl_o(lvl_w), .len_o(len_w));

  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end

  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc[0]) lf_i <= ~lf_i;
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_near(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e && g !== e + 16'h0001 && g !== e - 16'h0001) begin
      n_fail++;
      $display("[FAIL] %s expected about %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clock_i);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clock_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask

  task automatic wait_irq(output int t);
    int k;
    k = 0;
    do begin
      @(posedge clock_i);
      #1 k++;
    end while (irq_o !== 1'b1 && k < 20000);
    chk("irq seen", 16'h0001, {15'h0000, irq_o});
    t = cyc;
  endtask

  task automatic wait_run(input logic l, output logic [15:0] n);
    int k;
    k = 0;
    do begin
      @(posedge clock_i);
      #1 k++;
    end while (!(done_w === 1'b1 && lvl_w === l) && k < 20000);
    chk("pin run seen", 16'h0001, {15'h0000, done_w});
    n = len_w;
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge clock_i);
    n_fail++;
    test_done();
  end

  initial begin
    {resetn_i, wr_i, rd_i, sleep_i} = 4'h0;
    addr_i  = 4'h0;
    wdata_i = 8'h00;
    repeat (12) @(posedge clock_i);
    resetn_i <= 1'b1;
    for (i = 0; i < 4; i++) begin
      rd((i == 3) ? 4'hf : 4'(i), d);
      chk("reset read", 16'h0000, {8'h00, d});
    end
    chk("idle pin", 16'h0000, {14'h0000, oe_o, pin_o});
    $display("test reset done");
    for (i = 0; i < 6; i++) begin
      sleep_i <= (i == 5);
      wr(4'h1, mtab[i]);
      wr(4'h0, 8'h03);
      wait_irq(t0);
      wait_irq(t1);
      chk("irq spacing", stab[i], 16'(t1 - t0));
      wr(4'h0, 8'h02);
    end
    sleep_i <= 1'b0;
    $display("test clock select done");
    wr(4'h1, 8'h70);
    wr(4'h2, 8'ha0);
    wr(4'h0, 8'h03);
    wait_run(1'b1, w1);
    wait_run(1'b1, w2);
    chk_near("high odd", 16'd96, w1);
    chk("extended high", w1 - 16'h0001, w2);
    wait_run(1'b0, w1);
    wr(4'h0, 8'h02);
    rd(4'h4, d);
    chk("stop count", 16'h0000, {8'h00, d});
    chk("stop pin", 16'h0000, {15'h0000, pin_o});
    $display("test duty and extension done");
    wr(4'h1, 8'h71);
    wr(4'h2, 8'h20);
    chk("idle high pin", 16'h0003, {14'h0000, oe_o, pin_o});
    wr(4'h0, 8'h03);
    wait_run(1'b0, w1);
    chk_near("low odd", 16'd96, w1);
    wait_run(1'b1, w1);
    wr(4'h0, 8'h02);
    rd(4'h4, d);
    chk("stop high pin", 16'h0001, {15'h0000, pin_o});
    $display("test initial level done");
    wr(4'h1, 8'h72);
    wr(4'h2, 8'h20);
    wr(4'h0, 8'h03);
    wait_irq(t0);
    wr(4'h2, 8'h40);
    rd(4'h2, d);
    chk("buffered read", 16'h0040, {8'h00, d});
    for (i = 0; i < 2; i++) begin
      wait_run(1'b1, w1);
      chk_near("old duty", 16'd96, w1);
    end
    wait_run(1'b1, w1);
    chk_near("copied duty", 16'd64, w1);
    wr(4'h0, 8'h02);
    $display("test double buffer done");
    wr(4'h1, 8'h70);
    wr(4'h2, 8'h20);
    wr(4'h0, 8'h03);
    wait_irq(t0);
    wr(4'h2, 8'h40);
    wait_run(1'b1, w1);
    chk_near("direct duty", 16'd64, w1);
    wait_irq(t0);
    repeat (44) @(posedge clock_i);
    wr(4'h2, 8'h10);
    wait_run(1'b0, w1);
    chk_near("late match", 16'd144, w1);
    wait_irq(t0);
    wr(4'h2, 8'h01);
    wait_run(1'b0, w1);
    chk_near("equal count", 16'd2, w1);
    wr(4'h0, 8'h02);
    $display("test direct write done");
    test_done();
  end
endmodule // tb_top

bind timer_8bit_pwm_mode pwm_timer_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk_u (
  .clock_i(clock_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .pwm_output_pin_o(pwm_output_pin_o), .pwm_output_oe_o(pwm_output_oe_o),
  .channel0_irq_o(channel0_irq_o));
`default_nettype wire
